// ==== pkg/ssk_pkg.sv ====
// Purpose: shared constants for the security sign-on / key exchange codec
// Assumes: big-endian byte order on the message streams, first byte first
// Notes: context bits are word indices 31..0; the top bit is the version bit
package ssk_pkg;
	// legal (non-reserved) bits of each class byte
	localparam logic [7:0] PKA_LEGAL = 8'h01;
	localparam logic [7:0] HA_LEGAL = 8'h01;
	localparam logic [7:0] EA_LEGAL = 8'h0f;
	localparam logic [7:0] NS_LEGAL = 8'h01;
	// option bit positions inside the class bytes
	localparam int PKA_DH512_BIT = 0;
	localparam int HA_SHA1_BIT = 0;
	localparam int EA_CTR_BIT = 3;
	localparam int EA_CBC_BIT = 2;
	localparam int EA_DES56_BIT = 1;
	localparam int EA_DES40_BIT = 0;
	localparam int NS_64_BIT = 0;
	// parameter sizes in bytes tied to each option
	localparam logic [7:0] PKA_DH512_LEN = 8'h40;
	localparam logic [7:0] HA_SHA1_LEN = 8'h14;
	localparam logic [7:0] EA_CTR_LEN = 8'h18;
	localparam logic [7:0] EA_CBC_LEN = 8'h10;
	localparam logic [7:0] EA_DES56_LEN = 8'h08;
	localparam logic [7:0] NS_64_LEN = 8'h08;
	// context word layout
	localparam int CTX_VER_BIT = 31;
	localparam int CTX_IDT_BIT = 30;
	localparam int CTX_FLOW_HI = 29;
	localparam int CTX_FLOW_LO = 6;
	localparam int CTX_KEY_HI = 5;
	localparam int CTX_KEY_LO = 0;
	// main key exchange flags byte
	localparam int FL_SESS_BIT = 0;
	localparam int FL_INC_BIT = 1;
	localparam int FL_COOKIE_BIT = 2;
	localparam int FL_INIT_BIT = 3;
	localparam logic [7:0] FL_RSVD_MASK = 8'hf0;
	// message section lengths in bytes
	localparam logic [7:0] SO_LEN = 8'h08;
	localparam logic [7:0] CID_LEN = 8'h04;
	// register byte offsets
	localparam logic [7:0] REG_SUPP = 8'h00;
	localparam logic [7:0] REG_SEL = 8'h04;
	localparam logic [7:0] REG_STATE = 8'h08;
	localparam logic [7:0] REG_CTX = 8'h0c;
	localparam logic [7:0] REG_ERR = 8'h10;
	localparam logic [7:0] REG_SIZE = 8'h14;
	localparam logic [31:0] SUPP_RST = 32'h01010f01;
	// state register fields
	localparam int STA_CSN_BIT = 8;
	localparam int STA_KSN_BIT = 9;
	localparam int STA_SESS_BIT = 10;
	localparam int STA_INIT_BIT = 11;
	localparam int STA_NEG_BIT = 12;
	// sticky error bits
	localparam int ERR_RESP = 0;
	localparam int ERR_VER = 1;
	localparam int ERR_NONEG = 2;
	localparam int ERR_BUSY = 3;
	localparam int ERR_RSVD = 4;
	localparam int ERR_W = 5;
	typedef enum logic [1:0] {
		KIND_OFFER = 2'b00,
		KIND_KX = 2'b01,
		KIND_RESP = 2'b10
	} ssk_kind_t;
	typedef enum logic [1:0] {
		FLD_NONCE = 2'b00,
		FLD_MOD = 2'b01,
		FLD_GEN = 2'b10,
		FLD_PUB = 2'b11
	} ssk_fld_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SO = 3'b001,
		ST_RESP = 3'b010,
		ST_CID = 3'b011,
		ST_HDR = 3'b100,
		ST_FIELD = 3'b101
	} ssk_state_t;
endpackage

// ==== hw/ssk_class_pick.sv ====
// Purpose: choose one option of a class from offered, supported and legal bits
// Assumes: higher bit numbers are the stronger choices
// Notes: returns zero when nothing is common
`timescale 1ns/1ps
`default_nettype none
module ssk_class_pick #(
	parameter int W = 8
) (
	input wire logic [W-1:0] offer,
	input wire logic [W-1:0] supp,
	input wire logic [W-1:0] legal,
	output logic [W-1:0] pick
);
	logic [W-1:0] cand; // options both sides can use
	if (W < 1) begin : g_bad_w
		$error("ssk_class_pick needs W of at least 1");
	end
	// highest common option wins, at most one bit out
	always_comb begin
		cand = offer & supp & legal;
		pick = '0;
		for (int i = 0; i < W; i++) begin
			if (cand[i]) begin
				pick = '0;
				pick[i] = 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== hw/ssk_class_check.sv ====
// Purpose: judge a class byte seen in a returned sign-on response
// Assumes: offer is the class byte that was offered for this exchange
// Notes: an all-zero byte is a legal refusal, not an error
`timescale 1ns/1ps
`default_nettype none
module ssk_class_check #(
	parameter int W = 8
) (
	input wire logic [W-1:0] field,
	input wire logic [W-1:0] offer,
	input wire logic [W-1:0] legal,
	output logic bad
);
	if (W < 1) begin : g_bad_w
		$error("ssk_class_check needs W of at least 1");
	end
	// more than one bit, or a bit outside what was offered and legal
	always_comb begin
		bad = !$onehot0(field) || ((field & ~(offer & legal)) != '0);
	end
endmodule
`default_nettype wire

// ==== hw/ssk_codec.sv ====
// Purpose: terminal-side sign-on response builder and key exchange parser
// Assumes: rx and tx byte streams are in the clk domain; wishbone classic slave
// Notes: key arithmetic lives outside; fields are handed out byte by byte
`timescale 1ns/1ps
`default_nettype none
module ssk_codec
	import ssk_pkg::*;
#(
	parameter int EA_DES40_LEN = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [7:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_wdata,
	output logic [31:0] wb_rdata,
	output logic wb_ack,
	input wire logic rx_valid,
	input wire logic rx_sop,
	input wire ssk_pkg::ssk_kind_t rx_kind,
	input wire logic [7:0] rx_data,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	input wire logic tx_ready,
	output logic fld_valid,
	output logic [1:0] fld_id,
	output logic [7:0] fld_idx,
	output logic [7:0] fld_byte,
	output logic kx_done,
	output logic sess_key_sel,
	output logic [7:0] clone_cnt,
	output logic counter_sn,
	output logic cookie_sn,
	output logic cookie_regen,
	output logic auth_ignored
);
	import ssk_pkg::*;
	if (EA_DES40_LEN < 0 || EA_DES40_LEN > 255) begin : g_bad_len
		$error("EA_DES40_LEN must fit one byte");
	end
	localparam logic [7:0] DES40_LEN = 8'(EA_DES40_LEN); // size of the 40-bit DES option
	// receive side state
	ssk_state_t st_q, st_d;
	logic [7:0] cnt_q, cnt_d; // byte index within a section
	ssk_fld_t fid_q, fid_d; // field being streamed out
	logic [63:0] msg_q, msg_d; // sign-on bytes, newest in the low byte
	logic [7:0] flags_q, flags_d;
	logic [31:0] offer_q, offer_d; // class bytes of the last offer
	logic [31:0] ctx_q, ctx_d; // context word of the last offer
	logic fld_valid_q, fld_valid_d;
	logic [1:0] fld_id_q, fld_id_d;
	logic [7:0] fld_idx_q, fld_idx_d;
	logic [7:0] fld_byte_q, fld_byte_d;
	logic kx_done_q, kx_done_d;
	logic cookie_regen_q, cookie_regen_d;
	logic [7:0] clone_q, clone_d;
	logic csn_q, csn_d; // clone counter sequence bit
	logic ksn_q, ksn_d; // cookie sequence bit
	logic sess_q, sess_d;
	logic init_q, init_d;
	logic launch; // offer complete, build a response
	logic [ERR_W-1:0] err_set;
	// transmit side state
	logic tx_valid_q, tx_valid_d;
	logic [7:0] tx_data_q, tx_data_d;
	logic tx_last_q, tx_last_d;
	logic [7:0] tx_cnt_q, tx_cnt_d; // index of the byte on tx_data
	logic [63:0] resp_q, resp_d;
	logic [31:0] sel_q, sel_d; // negotiated choice per class
	logic neg_q, neg_d; // every class has a choice
	// bus side state
	logic [31:0] supp_q, supp_d; // options this terminal supports
	logic [31:0] rdata_q, rdata_d;
	logic ack_q, ack_d;
	logic [ERR_W-1:0] err_q, err_d;
	logic [ERR_W-1:0] err_w1c;
	// combinational helpers
	logic [63:0] word; // sign-on message including the byte now arriving
	logic [31:0] pick; // chosen class bytes
	logic [3:0] chk_bad; // per-class verdict on a returned response
	logic [7:0] pka_len, ha_len, ea_len, ns_len;
	logic [7:0] cur_len;
	logic [7:0] byte_adr;
	logic [31:0] ctx_out;
	logic [31:0] legal;

	assign word = {msg_q[55:0], rx_data};
	assign legal = {PKA_LEGAL, HA_LEGAL, EA_LEGAL, NS_LEGAL};
	// the version bit is forced clear, everything else of the context echoes
	assign ctx_out = {1'b0, word[CTX_IDT_BIT:0]};

	// one selector and one checker per class byte
	for (genvar g = 0; g < 4; g++) begin : g_class
		ssk_class_pick #(.W(8)) u_pick (
			.offer(word[63-8*g -: 8]),
			.supp(supp_q[31-8*g -: 8]),
			.legal(legal[31-8*g -: 8]),
			.pick(pick[31-8*g -: 8])
		);
		ssk_class_check #(.W(8)) u_check (
			.field(word[63-8*g -: 8]),
			.offer(offer_q[31-8*g -: 8]),
			.legal(legal[31-8*g -: 8]),
			.bad(chk_bad[g])
		);
	end

	// parameter sizes follow the negotiated choice
	always_comb begin
		pka_len = sel_q[24+PKA_DH512_BIT] ? PKA_DH512_LEN : 8'h00;
		ha_len = sel_q[16+HA_SHA1_BIT] ? HA_SHA1_LEN : 8'h00;
		if (sel_q[8+EA_CTR_BIT]) begin
			ea_len = EA_CTR_LEN;
		end else if (sel_q[8+EA_CBC_BIT]) begin
			ea_len = EA_CBC_LEN;
		end else if (sel_q[8+EA_DES56_BIT]) begin
			ea_len = EA_DES56_LEN;
		end else if (sel_q[8+EA_DES40_BIT]) begin
			ea_len = DES40_LEN;
		end else begin
			ea_len = 8'h00;
		end
		ns_len = sel_q[NS_64_BIT] ? NS_64_LEN : 8'h00;
		cur_len = (fid_q == FLD_NONCE) ? ns_len : pka_len;
	end

	// receive parser: sign-on offers, returned responses, main key exchange
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		fid_d = fid_q;
		msg_d = msg_q;
		flags_d = flags_q;
		offer_d = offer_q;
		ctx_d = ctx_q;
		fld_valid_d = 1'b0;
		fld_id_d = fld_id_q;
		fld_idx_d = fld_idx_q;
		fld_byte_d = fld_byte_q;
		kx_done_d = 1'b0;
		cookie_regen_d = 1'b0;
		clone_d = clone_q;
		csn_d = csn_q;
		ksn_d = ksn_q;
		sess_d = sess_q;
		init_d = init_q;
		launch = 1'b0;
		err_set = '0;
		if (rx_valid && rx_sop) begin
			// a start byte always restarts the parser
			msg_d = word;
			cnt_d = 8'h01;
			if (rx_kind == KIND_OFFER) begin
				st_d = ST_SO;
			end else if (rx_kind == KIND_RESP) begin
				st_d = ST_RESP;
			end else if (rx_kind == KIND_KX && neg_q && ns_len != 8'h00 && pka_len != 8'h00) begin
				st_d = ST_CID;
			end else begin
				// key exchange before a usable negotiation is dropped
				st_d = ST_IDLE;
				err_set[ERR_NONEG] = (rx_kind == KIND_KX);
			end
		end else if (rx_valid) begin
			case (st_q)
				ST_SO, ST_RESP: begin
					msg_d = word;
					cnt_d = 8'(cnt_q + 8'h01);
					if (cnt_q == 8'(SO_LEN - 8'h01)) begin
						st_d = ST_IDLE;
						if (st_q == ST_SO) begin
							offer_d = word[63:32];
							ctx_d = word[31:0];
							launch = 1'b1;
							err_set[ERR_VER] = word[CTX_VER_BIT];
						end else begin
							err_set[ERR_RESP] = |chk_bad;
						end
					end
				end
				ST_CID: begin
					// connection id content is not looked at
					cnt_d = 8'(cnt_q + 8'h01);
					if (cnt_q == 8'(CID_LEN - 8'h01)) begin
						st_d = ST_HDR;
						cnt_d = 8'h00;
					end
				end
				ST_HDR: begin
					if (cnt_q == 8'h00) begin
						flags_d = rx_data;
						err_set[ERR_RSVD] = (rx_data & FL_RSVD_MASK) != 8'h00;
						cnt_d = 8'h01;
					end else begin
						// reserved byte is skipped whatever it holds
						st_d = ST_FIELD;
						cnt_d = 8'h00;
						fid_d = FLD_NONCE;
					end
				end
				ST_FIELD: begin
					fld_valid_d = 1'b1;
					fld_id_d = fid_q;
					fld_idx_d = cnt_q;
					fld_byte_d = rx_data;
					cnt_d = 8'(cnt_q + 8'h01);
					if (cnt_q == 8'(cur_len - 8'h01)) begin
						cnt_d = 8'h00;
						fid_d = ssk_fld_t'(2'(fid_q + 2'b01));
						if (fid_q == FLD_PUB) begin
							st_d = ST_IDLE;
							kx_done_d = 1'b1;
							sess_d = flags_q[FL_SESS_BIT];
							init_d = flags_q[FL_INIT_BIT];
							if (flags_q[FL_COOKIE_BIT]) begin
								// cookie renewal overrides an increment in the same message
								cookie_regen_d = 1'b1;
								clone_d = 8'h00;
								csn_d = 1'b0;
								ksn_d = !ksn_q;
							end else if (flags_q[FL_INC_BIT]) begin
								clone_d = 8'(clone_q + 8'h01);
								csn_d = !csn_q;
							end
						end
					end
				end
				default: begin
					st_d = ST_IDLE;
				end
			endcase
		end
	end

	// receive registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= ST_IDLE;
			cnt_q <= 8'h00;
			fid_q <= FLD_NONCE;
			msg_q <= 64'h0;
			flags_q <= 8'h00;
			offer_q <= 32'h0;
			ctx_q <= 32'h0;
			fld_valid_q <= 1'b0;
			fld_id_q <= 2'b00;
			fld_idx_q <= 8'h00;
			fld_byte_q <= 8'h00;
			kx_done_q <= 1'b0;
			cookie_regen_q <= 1'b0;
			clone_q <= 8'h00;
			csn_q <= 1'b0;
			ksn_q <= 1'b0;
			sess_q <= 1'b0;
			init_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			fid_q <= fid_d;
			msg_q <= msg_d;
			flags_q <= flags_d;
			offer_q <= offer_d;
			ctx_q <= ctx_d;
			fld_valid_q <= fld_valid_d;
			fld_id_q <= fld_id_d;
			fld_idx_q <= fld_idx_d;
			fld_byte_q <= fld_byte_d;
			kx_done_q <= kx_done_d;
			cookie_regen_q <= cookie_regen_d;
			clone_q <= clone_d;
			csn_q <= csn_d;
			ksn_q <= ksn_d;
			sess_q <= sess_d;
			init_q <= init_d;
		end
	end

	// response sender; a second offer during sending is refused
	always_comb begin
		tx_valid_d = tx_valid_q;
		tx_data_d = tx_data_q;
		tx_last_d = tx_last_q;
		tx_cnt_d = tx_cnt_q;
		resp_d = resp_q;
		sel_d = sel_q;
		neg_d = neg_q;
		if (tx_valid_q && tx_ready) begin
			if (tx_last_q) begin
				tx_valid_d = 1'b0;
				tx_last_d = 1'b0;
			end else begin
				resp_d = {resp_q[55:0], 8'h00};
				tx_data_d = resp_q[55:48];
				tx_cnt_d = 8'(tx_cnt_q + 8'h01);
				tx_last_d = (tx_cnt_q == 8'(SO_LEN - 8'h02));
			end
		end
		if (launch && !tx_valid_q) begin
			resp_d = {pick, ctx_out};
			tx_data_d = pick[31:24];
			tx_valid_d = 1'b1;
			tx_last_d = 1'b0;
			tx_cnt_d = 8'h00;
			sel_d = pick;
			// a zero class leaves the codec without a usable negotiation
			neg_d = (pick[31:24] != 8'h00) && (pick[23:16] != 8'h00) &&
				(pick[15:8] != 8'h00) && (pick[7:0] != 8'h00);
		end
	end

	// transmit registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_valid_q <= 1'b0;
			tx_data_q <= 8'h00;
			tx_last_q <= 1'b0;
			tx_cnt_q <= 8'h00;
			resp_q <= 64'h0;
			sel_q <= 32'h0;
			neg_q <= 1'b0;
		end else begin
			tx_valid_q <= tx_valid_d;
			tx_data_q <= tx_data_d;
			tx_last_q <= tx_last_d;
			tx_cnt_q <= tx_cnt_d;
			resp_q <= resp_d;
			sel_q <= sel_d;
			neg_q <= neg_d;
		end
	end

	// wishbone slave: one wait state, unmapped reads give zero
	always_comb begin
		byte_adr = {wb_adr[7:2], 2'b00};
		ack_d = wb_cyc && wb_stb && !ack_q;
		supp_d = supp_q;
		rdata_d = rdata_q;
		err_w1c = '0;
		if (ack_d && wb_we) begin
			if (byte_adr == REG_SUPP) begin
				for (int b = 0; b < 4; b++) begin
					if (wb_sel[b]) begin
						supp_d[8*b +: 8] = wb_wdata[8*b +: 8];
					end
				end
			end else if (byte_adr == REG_ERR && wb_sel[0]) begin
				err_w1c = wb_wdata[ERR_W-1:0];
			end
		end
		if (ack_d && !wb_we) begin
			if (byte_adr == REG_SUPP) begin
				rdata_d = supp_q;
			end else if (byte_adr == REG_SEL) begin
				rdata_d = sel_q;
			end else if (byte_adr == REG_STATE) begin
				rdata_d = {19'h0, neg_q, init_q, sess_q, ksn_q, csn_q, clone_q};
			end else if (byte_adr == REG_CTX) begin
				rdata_d = ctx_q;
			end else if (byte_adr == REG_ERR) begin
				rdata_d = {{(32-ERR_W){1'b0}}, err_q};
			end else if (byte_adr == REG_SIZE) begin
				rdata_d = {pka_len, ha_len, ea_len, ns_len};
			end else begin
				rdata_d = 32'h0;
			end
		end
		// a new error in the clearing cycle survives the clear
		err_d = (err_q & ~err_w1c) | err_set;
		err_d[ERR_BUSY] = (err_q[ERR_BUSY] & !err_w1c[ERR_BUSY]) | (launch & tx_valid_q);
	end

	// bus registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			supp_q <= SUPP_RST;
			rdata_q <= 32'h0;
			ack_q <= 1'b0;
			err_q <= '0;
		end else begin
			supp_q <= supp_d;
			rdata_q <= rdata_d;
			ack_q <= ack_d;
			err_q <= err_d;
		end
	end

	assign wb_rdata = rdata_q;
	assign wb_ack = ack_q;
	assign tx_valid = tx_valid_q;
	assign tx_data = tx_data_q;
	assign tx_last = tx_last_q;
	assign fld_valid = fld_valid_q;
	assign fld_id = fld_id_q;
	assign fld_idx = fld_idx_q;
	assign fld_byte = fld_byte_q;
	assign kx_done = kx_done_q;
	assign sess_key_sel = sess_q;
	assign clone_cnt = clone_q;
	assign counter_sn = csn_q;
	assign cookie_sn = ksn_q;
	assign cookie_regen = cookie_regen_q;
	assign auth_ignored = init_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	chk_pick_onehot: assert property (tx_valid_q && tx_cnt_q < 8'h04 |-> $onehot0(tx_data_q))
		else $error("response class byte has several bits");
	chk_none_zero: assert property (tx_valid_q && tx_cnt_q == 8'h00 &&
		((offer_q[31:24] & supp_q[31:24] & PKA_LEGAL) == 8'h00) |-> tx_data_q == 8'h00)
		else $error("refused class not sent as zero");
	chk_enc_rsvd: assert property (tx_valid_q && tx_cnt_q == 8'h02 |-> tx_data_q[7:4] == 4'h0)
		else $error("reserved encryption bits sent");
	chk_pka_rsvd: assert property (tx_valid_q && tx_cnt_q == 8'h00 |-> tx_data_q[7:1] == 7'h00)
		else $error("reserved public key bits sent");
	chk_ver_zero: assert property (tx_valid_q && tx_cnt_q == 8'h04 |-> !tx_data_q[7])
		else $error("context version bit set");
	chk_mod_len: assert property (fld_valid_q && fld_id_q != FLD_NONCE |-> fld_idx_q < 8'h40)
		else $error("public key field too long");
	chk_clone_inc: assert property (kx_done_q && flags_q[FL_INC_BIT] && !flags_q[FL_COOKIE_BIT]
		|-> clone_q == 8'($past(clone_q) + 8'h01))
		else $error("clone counter not incremented");
	chk_cookie_clr: assert property (cookie_regen_q |-> clone_q == 8'h00 && kx_done_q)
		else $error("clone counter not cleared on cookie renewal");
	chk_sess_sel: assert property (kx_done_q |-> sess_q == flags_q[FL_SESS_BIT])
		else $error("session key select does not follow flags");
	chk_resp_err: assert property (rx_valid && !rx_sop && st_q == ST_RESP &&
		cnt_q == 8'h07 && (|chk_bad) |=> err_q[ERR_RESP])
		else $error("bad returned response not flagged");
	chk_wb_ack: assert property (ack_q |=> !ack_q)
		else $error("ack held for two cycles");
endmodule
`default_nettype wire

// ==== tb/ssk_ncc_model.sv ====
// Purpose: behavioural control centre that sends offers and key exchanges
// Assumes: one byte per cycle while sending; the response sink stalls at random
// Notes: idle rx_data shows the inverse of the last byte so stale data never looks valid
`timescale 1ns/1ps
`default_nettype none
module ssk_ncc_model
	import ssk_pkg::*;
(
	input wire logic clk,
	output logic rx_valid,
	output logic rx_sop,
	output ssk_pkg::ssk_kind_t rx_kind,
	output logic [7:0] rx_data,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready
);
	logic [8:0] resp_q[$]; // taken response bytes, last flag on top
	initial begin
		rx_valid = 1'b0;
		rx_sop = 1'b0;
		rx_kind = KIND_OFFER;
		rx_data = 8'h00;
		tx_ready = 1'b0;
	end
	// sink takes a byte on valid and ready; stalls about one cycle in four
	always @(posedge clk) begin
		if (tx_valid && tx_ready) begin
			resp_q.push_back({tx_last, tx_data});
		end
		tx_ready <= ($urandom_range(3) != 0);
	end
	// known field pattern so the bench can predict every field byte
	function automatic logic [7:0] fbyte(input int id, input int idx);
		return 8'((id * 83) + (idx * 7) + 1);
	endfunction
	// one byte per cycle; the first carries the start mark and kind
	// a ninth offer byte starts a second offer at once, with no idle gap
	task automatic send(input ssk_kind_t k, input logic [7:0] b[$]);
		foreach (b[i]) begin
			@(posedge clk);
			rx_valid <= 1'b1;
			rx_sop <= (i == 0) || (k == KIND_OFFER && i == 8);
			rx_kind <= k;
			rx_data <= b[i];
		end
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_sop <= 1'b0;
		rx_data <= ~b[b.size()-1];
	endtask
	// zero connection id, flags, zero byte, then nonce and three key fields
	task automatic send_kx(input logic [7:0] flags, input int nlen, input int plen);
		logic [7:0] b[$];
		b = {8'h00, 8'h00, 8'h00, 8'h00, flags, 8'h00};
		for (int f = 0; f < 4; f++) begin
			for (int i = 0; i < ((f == 0) ? nlen : plen); i++) begin
				b.push_back(fbyte(f, i));
			end
		end
		send(KIND_KX, b);
	endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the sign-on and key exchange codec
// Assumes: default parameters; the centre model drives the byte stream
// Notes: picks and counter values are predicted here, never read back first
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ssk_pkg::*;
	localparam logic [31:0] LG = {PKA_LEGAL, HA_LEGAL, EA_LEGAL, NS_LEGAL};
	logic clk, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack, rx_valid, rx_sop, tx_valid, tx_last;
	logic [7:0] wb_adr, rx_data, tx_data, fld_idx, fld_byte, clone_cnt, exp_cnt, lf;
	logic [3:0] wb_sel;
	logic [31:0] wb_wdata, wb_rdata, sel, ctx, q;
	logic [1:0] fld_id;
	logic [7:0] bq[$]; // scratch message bytes
	ssk_kind_t rx_kind;
	logic tx_ready, fld_valid, kx_done, sess_key_sel, counter_sn, cookie_sn, cookie_regen;
	logic auth_ignored, exp_csn, exp_ksn, regen_seen;
	int fail_count, compares, eid, eix, done_cnt;
	// design at default sizes
	ssk_codec dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
		.wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdata(wb_wdata), .wb_rdata(wb_rdata),
		.wb_ack(wb_ack), .rx_valid(rx_valid), .rx_sop(rx_sop), .rx_kind(rx_kind),
		.rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.tx_ready(tx_ready), .fld_valid(fld_valid), .fld_id(fld_id), .fld_idx(fld_idx),
		.fld_byte(fld_byte), .kx_done(kx_done), .sess_key_sel(sess_key_sel),
		.clone_cnt(clone_cnt), .counter_sn(counter_sn), .cookie_sn(cookie_sn),
		.cookie_regen(cookie_regen), .auth_ignored(auth_ignored));
	// centre side of the stream
	ssk_ncc_model ncc (.clk(clk), .rx_valid(rx_valid), .rx_sop(rx_sop), .rx_kind(rx_kind),
		.rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.tx_ready(tx_ready));
	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic wrap_up();
		$display("compares %0d errors %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic tmo();
		fail_count++;
		$display("Error at %0t: wait timed out", $time);
		wrap_up();
	endtask
	task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: output %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_reg(input logic [7:0] a, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: reg %h read %h expected %h", $time, a, got, exp);
		end
	endtask
	// classic single cycle; request held until ack is sampled high
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_wdata <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		q = wb_rdata;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (wb_ack !== 1'b1) tmo();
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk_reg(a, q, exp);
	endtask
	// strongest bit left after masking; zero when nothing is common
	function automatic logic [7:0] pick(input logic [7:0] o);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (o[i]) r = 8'h01 << i;
		end
		return r;
	endfunction
	// one offer, its eight returned bytes and the readback
	task automatic offer(input logic [31:0] cls, input logic [31:0] cx, input logic [31:0] sp);
		logic [63:0] e;
		logic [31:0] sz;
		int n;
		for (int c = 0; c < 4; c++) begin
			sel[c*8+:8] = pick(cls[c*8+:8] & sp[c*8+:8] & LG[c*8+:8]);
		end
		ctx = cx & 32'h7fffffff;
		e = {sel, ctx};
		bq = {cls[31:24], cls[23:16], cls[15:8], cls[7:0], cx[31:24], cx[23:16], cx[15:8], cx[7:0]};
		ncc.resp_q.delete();
		ncc.send(KIND_OFFER, bq);
		for (n = 0; n < 100 && ncc.resp_q.size() < 8; n++) begin
			@(negedge clk);
		end
		if (ncc.resp_q.size() != 8) tmo();
		for (int i = 0; i < 8; i++) begin
			chk_out(ncc.resp_q[i], {i == 7, e[63-8*i-:8]});
		end
		rchk(REG_SEL, sel);
		rchk(REG_CTX, cx);
		if (sel[31:24] != 0 && sel[23:16] != 0 && sel[15:8] != 0 && sel[7:0] != 0) begin
			sz = {PKA_DH512_LEN, HA_SHA1_LEN, 8'h08, NS_64_LEN};
			if (sel[15:8] == 8'h08) sz[15:8] = EA_CTR_LEN;
			if (sel[15:8] == 8'h04) sz[15:8] = EA_CBC_LEN;
			rchk(REG_SIZE, sz);
		end
	endtask
	// field pulses checked against the model's byte pattern
	always @(posedge clk) begin
		if (fld_valid === 1'b1) begin
			chk_out({fld_id, fld_idx, fld_byte}, {eid[1:0], eix[7:0], ncc.fbyte(eid, eix)});
			eix++;
			if (eix == ((eid == 0) ? 8 : 64)) begin
				eid++;
				eix = 0;
			end
		end
		if (kx_done === 1'b1) begin
			done_cnt++;
			regen_seen = cookie_regen;
		end
	end
	// one key exchange; flag effects predicted here, cookie beats increment
	task automatic kx(input logic [7:0] f);
		int n0;
		int n;
		n0 = done_cnt;
		eid = 0;
		eix = 0;
		lf = f;
		ncc.send_kx(f, 8, 64);
		for (n = 0; n < 20 && done_cnt == n0; n++) begin
			@(negedge clk);
		end
		if (done_cnt == n0) tmo();
		if (f[2]) begin
			exp_cnt = 8'h00;
			exp_csn = 1'b0;
			exp_ksn = ~exp_ksn;
		end else if (f[1]) begin
			exp_cnt++;
			exp_csn = ~exp_csn;
		end
		chk_out({clone_cnt, counter_sn, cookie_sn}, {exp_cnt, exp_csn, exp_ksn});
		chk_out({sess_key_sel, auth_ignored, regen_seen}, {f[0], f[3], f[2]});
	endtask
	// main sequence
	initial begin
		q = $urandom(32'h2c037ebe);
		{sys_rst, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdata} = {4'h8, 8'h00, 4'hf, 32'h0};
		{exp_cnt, exp_csn, exp_ksn, regen_seen, lf} = '0;
		{fail_count, compares, eid, eix, done_cnt} = '0;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		// reset values, last one unmapped
		for (int a = 0; a < 7; a++) begin
			rchk(8'(a * 4), (a == 0) ? SUPP_RST : 32'h0);
		end
		// each encryption code alone, then mixed; the last offer sets the version bit
		for (int k = 0; k < 6; k++) begin
			q = $urandom() & 32'h7fffffff;
			q[31] = (k == 5);
			offer({8'h01, 8'h01, (k < 4) ? 8'(1 << k) : 8'($urandom_range(15, 1)), 8'h01}, q, SUPP_RST);
		end
		rchk(REG_ERR, 32'h2);
		wb(1'b1, REG_ERR, 32'h1f);
		// no usable key agreement or cipher: zero bytes, key exchange refused
		wb(1'b1, REG_SUPP, 32'h00010e01);
		rchk(REG_SUPP, 32'h00010e01);
		offer(32'h01010101, 32'h0, 32'h00010e01);
		ncc.send_kx(8'h02, 8, 64);
		repeat (10) @(negedge clk);
		chk_out(done_cnt, 0);
		rchk(REG_ERR, 32'h4);
		wb(1'b1, REG_ERR, 32'h1f);
		wb(1'b1, REG_SUPP, SUPP_RST);
		offer(32'h01010301, $urandom() & 32'h7fffffff, SUPP_RST);
		// returned responses: good, refusal, then an option never offered
		bq = {8'h01, 8'h01, 8'h02, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
		ncc.send(KIND_RESP, bq);
		bq[2] = 8'h00;
		ncc.send(KIND_RESP, bq);
		rchk(REG_ERR, 32'h0);
		bq[0] = 8'h03;
		ncc.send(KIND_RESP, bq);
		rchk(REG_ERR, 32'h1);
		// a second offer right behind the first lands while the answer still goes out
		bq = {8'h01, 8'h01, 8'h0f, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
		ncc.send(KIND_OFFER, bq);
		rchk(REG_SEL, 32'h01010801);
		rchk(REG_ERR, 32'h9);
		// all flag codes, random ones, a cookie reset, then a full counter wrap
		for (int k = 0; k < 293; k++) begin
			kx((k < 16) ? 8'(k) : (k < 36) ? 8'($urandom_range(15)) : (k == 36) ? 8'h04 : 8'(2 | $urandom_range(1)));
		end
		rchk(REG_STATE, {19'h0, 1'b1, lf[3], lf[0], exp_ksn, exp_csn, exp_cnt});
		eid = 0;
		eix = 0;
		ncc.send_kx(8'hf0, 8, 64);
		repeat (4) @(negedge clk);
		rchk(REG_ERR, 32'h19);
		wrap_up();
	end
endmodule
`default_nettype wire
